// *** rtl/valve_supervisor_pkg.sv ***
package valve_supervisor_pkg;
   // ----------------------------------------
   // scaling and thresholds
   // ----------------------------------------
   // currents in microamps, volts in millivolts, positions in 1/65535 of full travel
   localparam logic [15:0] ANALOG_OVER_UA = 16'h55F0;   // 22000 uA
   localparam logic [15:0] ANALOG_UNDER_UA = 16'h07D0;  // 2000 uA
   localparam logic [15:0] SUPPLY_UNDER_MV = 16'h4268;  // 17000 mV
   localparam logic [15:0] SUPPLY_OVER_MV = 16'h80E8;   // 33000 mV
   localparam logic [15:0] CLOSED_POS = 16'h0000;
   // filter coefficient 0.002 as fraction of 2^20
   localparam logic [11:0] FILT_COEFF = 12'h831;         // 2097 / 1048576
   localparam int FILT_SHIFT = 20;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 10;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   localparam logic [15:0] MISMATCH_DELAY_MIN_MS = 16'h0032; // 50 ms
   localparam logic [15:0] MISMATCH_DELAY_MAX_MS = 16'h1388; // 5000 ms
   localparam logic [15:0] MISMATCH_LIMIT_RESET = 16'h028F; // 1% of travel
   localparam logic [19:0] MS_CYCLES_W = 20'(MS_CYCLES);
   // ----------------------------------------
   // wishbone register map (word offsets as byte addresses)
   // ----------------------------------------
   localparam logic [7:0] REG_COMMAND = 8'h00;
   localparam logic [7:0] REG_MISMATCH = 8'h04;
   localparam logic [7:0] REG_GAP = 8'h08;
   localparam logic [7:0] REG_CONFIG = 8'h0C;
   localparam logic [7:0] REG_FAULTS = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_FEEDBACK = 8'h18;
   localparam logic [7:0] REG_FILTERED = 8'h1C;
   // command bits
   localparam int CMD_SHUTDOWN = 0;
   localparam int CMD_RESET = 1;
   localparam int CMD_CHECK = 2;
   localparam int CMD_ANALOG_FIRST = 3;
   localparam int CMD_FALLBACK = 4;
   // fault bit positions
   localparam int F_ANALOG_OVER = 0;
   localparam int F_ANALOG_UNDER = 1;
   localparam int F_MISMATCH = 2;
   localparam int F_NETWORK = 3;
   localparam int F_GAP_A = 4;
   localparam int F_GAP_B = 5;
   localparam int F_SUPPLY_UNDER = 6;
   localparam int F_SUPPLY_OVER = 7;
   localparam int F_STORE = 8;
   localparam int F_SENSOR_A = 9;
   localparam int F_SENSOR_B = 10;
   localparam int F_POSITION = 11;
   localparam int F_COLD_START = 12;
   localparam int NUM_FAULTS = 13;
   localparam logic [12:0] FAULT_RESET = 13'h1000;
   // feedback pick modes
   localparam logic [1:0] PICK_HIGHER = 2'h0;
   localparam logic [1:0] PICK_LOWER = 2'h1;
   localparam logic [1:0] PICK_MEAN = 2'h2;
   // ----------------------------------------
   // shutdown states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_POS_SHUTDOWN = 3'b010,
      ST_SYS_SHUTDOWN = 3'b100
   } sd_state_t;
endpackage : valve_supervisor_pkg

// *** rtl/valve_fault_supervisor.sv ***
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
// Overview of operation
// - analog current above 22 mA latches over fault and shuts down
// - analog current below 2 mA latches under fault and shuts down
// - analog-first bit picks analog demand when both healthy, else network demand
// - fallback bit switches to analog on network failure; off together with analog-first bit disables analog checks
// - demand mismatch flag when fallback bit set and digital and analog differ beyond limit
// - mismatch shutdown only after limit exceeded for the configured delay
// - network fault on bad message, duplicate node, bus off or silence
// - dual feedback picks higher, lower or mean reading by mode
// - first gap fault when resolver readings differ beyond limit a
// - second gap fault when resolver readings differ beyond limit b
// - supply under fault below 17 V, over fault above 33 V
// - store fault only when both parameter copies bad on access
// - filtered current moves by 0.002 of the difference each sample
// - sensor a fault on bad resolver 1; run on resolver 2 if fitted
// - sensor b fault on bad resolver 2; run on resolver 1 if dual
// - feedback differing from demand sets position fault and shuts down
// - cold start flag set at power-up; shutdown held until reset
// - only a rising reset command edge leaves shutdown and clears flags
// - sensor check runs only when bit set, shut down and closed
// - shutdown command forces shutdown and the shutdown status bit
// - position shutdown: current-control closure, milliamp output zero, status shutdown
// - system shutdown: last pwm closure attempt, milliamp output zero, status shutdown
// - pick mode codes: 0 higher, 1 lower, 2 mean
module valve_fault_supervisor
   import valve_supervisor_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [7:0] wbAdrI,
   input wire logic [3:0] wbSelI,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAckO,
   input wire logic [15:0] analogCurrentUa,
   input wire logic [15:0] analogDemand,
   input wire logic [15:0] networkDemand,
   input wire logic msgBad,
   input wire logic nodeDuplicate,
   input wire logic busOff,
   input wire logic msgSilence,
   input wire logic [15:0] supplyMv,
   input wire logic [15:0] angleA,
   input wire logic [15:0] angleB,
   input wire logic angleAValid,
   input wire logic angleBValid,
   input wire logic dualFitted,
   input wire logic storeAccess,
   input wire logic copyAGood,
   input wire logic copyBGood,
   input wire logic [15:0] currentSample,
   input wire logic currentStrobe,
   output logic repairCopyA,
   output logic repairCopyB,
   output logic [15:0] activeDemand,
   output logic [15:0] feedbackPos,
   output logic [15:0] filteredCurrent,
   output logic currentCloseDrive,
   output logic pwmCloseDrive,
   output logic milliampZero,
   output logic statusShutdown,
   output logic sensorCheckRun
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
      absDiff = (a > b) ? (a - b) : (b - a);
   endfunction : absDiff

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [4:0] command_reg;
   logic [15:0] mismatchLimit_reg;
   logic [15:0] mismatchDelay_reg;
   logic [15:0] gapLimitA_reg;
   logic [15:0] gapLimitB_reg;
   logic [1:0] pickMode_reg;
   logic resetPrev_reg;
   logic [NUM_FAULTS-1:0] faults_reg;
   logic [NUM_FAULTS-1:0] cause;
   sd_state_t state_reg;
   sd_state_t state_next;
   logic [19:0] msCount_reg;
   logic [15:0] mismatchMs_reg;
   logic [35:0] filt_reg;
   logic wbAccess;
   logic resetEdge;

   assign wbAccess = wbCycI && wbStbI && !wbAckO;
   assign resetEdge = command_reg[CMD_RESET] && !resetPrev_reg;

   // ----------------------------------------
   // wishbone slave, one registered ack a cycle after the strobe
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wbAckO <= 1'b0;
      end else begin
         wbAckO <= wbAccess;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         command_reg <= 5'h00;
         mismatchLimit_reg <= MISMATCH_LIMIT_RESET;
         mismatchDelay_reg <= MISMATCH_DELAY_MIN_MS;
         gapLimitA_reg <= 16'h0000;
         gapLimitB_reg <= 16'h0000;
         pickMode_reg <= PICK_HIGHER;
      end else if (wbCycI && wbStbI && wbWeI && wbAckO) begin
         // write lands on the ack edge, where the master sees it done
         case (wbAdrI)
            REG_COMMAND: begin
               if (wbSelI[0]) command_reg <= wbDatI[4:0];
            end
            REG_MISMATCH: begin
               if (wbSelI[0]) mismatchLimit_reg[7:0] <= wbDatI[7:0];
               if (wbSelI[1]) mismatchLimit_reg[15:8] <= wbDatI[15:8];
               if (wbSelI[2]) mismatchDelay_reg[7:0] <= wbDatI[23:16];
               if (wbSelI[3]) mismatchDelay_reg[15:8] <= wbDatI[31:24];
            end
            REG_GAP: begin
               if (wbSelI[0]) gapLimitA_reg[7:0] <= wbDatI[7:0];
               if (wbSelI[1]) gapLimitA_reg[15:8] <= wbDatI[15:8];
               if (wbSelI[2]) gapLimitB_reg[7:0] <= wbDatI[23:16];
               if (wbSelI[3]) gapLimitB_reg[15:8] <= wbDatI[31:24];
            end
            REG_CONFIG: begin
               // unused code 3 behaves as mean
               if (wbSelI[0]) pickMode_reg <= wbDatI[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wbDatO <= 32'h0000_0000;
      end else if (wbAccess && !wbWeI) begin
         case (wbAdrI)
            REG_COMMAND: wbDatO <= {27'h0, command_reg};
            REG_MISMATCH: wbDatO <= {mismatchDelay_reg, mismatchLimit_reg};
            REG_GAP: wbDatO <= {gapLimitB_reg, gapLimitA_reg};
            REG_CONFIG: wbDatO <= {30'h0, pickMode_reg};
            REG_FAULTS: wbDatO <= {19'h0, faults_reg};
            REG_STATUS: wbDatO <= {27'h0, sensorCheckRun, statusShutdown, state_reg};
            REG_FEEDBACK: wbDatO <= {activeDemand, feedbackPos};
            REG_FILTERED: wbDatO <= {16'h0, filteredCurrent};
            default: wbDatO <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         resetPrev_reg <= 1'b0;
      end else begin
         resetPrev_reg <= command_reg[CMD_RESET];
      end
   end

   // ----------------------------------------
   // demand selection and feedback
   // ----------------------------------------
   logic analogUsed;
   logic analogHealthy;
   logic networkFail;
   logic sensorAOk;
   logic sensorBOk;
   logic [16:0] angleSum;

   assign networkFail = msgBad || nodeDuplicate || busOff || msgSilence;
   assign analogUsed = command_reg[CMD_FALLBACK] || command_reg[CMD_ANALOG_FIRST];
   assign analogHealthy = analogUsed && !cause[F_ANALOG_OVER] && !cause[F_ANALOG_UNDER];
   assign sensorAOk = angleAValid;
   assign sensorBOk = angleBValid && dualFitted;
   assign angleSum = {1'b0, angleA} + {1'b0, angleB};

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         activeDemand <= 16'h0000;
      end else if (command_reg[CMD_ANALOG_FIRST] && analogHealthy && !networkFail) begin
         activeDemand <= analogDemand;
      end else if (command_reg[CMD_FALLBACK] && networkFail && analogHealthy) begin
         activeDemand <= analogDemand;
      end else begin
         activeDemand <= networkDemand;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         feedbackPos <= 16'h0000;
      end else if (sensorAOk && sensorBOk) begin
         case (pickMode_reg)
            PICK_HIGHER: feedbackPos <= (angleA > angleB) ? angleA : angleB;
            PICK_LOWER: feedbackPos <= (angleA < angleB) ? angleA : angleB;
            default: feedbackPos <= angleSum[16:1];
         endcase
      end else if (sensorBOk) begin
         feedbackPos <= angleB;
      end else if (sensorAOk) begin
         feedbackPos <= angleA;
      end
   end

   // ----------------------------------------
   // fault causes
   // ----------------------------------------
   logic mismatchOver;
   logic mismatchExpired;
   logic storeBothBad;
   logic checkAllowed;

   // limit of 0 flags any difference at all; control system keeps 50..5000 ms
   assign mismatchOver = command_reg[CMD_FALLBACK]
      && (absDiff(networkDemand, analogDemand) > mismatchLimit_reg);
   assign mismatchExpired = mismatchOver && (mismatchMs_reg >= mismatchDelay_reg);
   assign storeBothBad = storeAccess && !copyAGood && !copyBGood;

   always_comb begin
      cause = '0;
      cause[F_ANALOG_OVER] = analogUsed && (analogCurrentUa > ANALOG_OVER_UA);
      cause[F_ANALOG_UNDER] = analogUsed && (analogCurrentUa < ANALOG_UNDER_UA);
      cause[F_MISMATCH] = mismatchOver;
      cause[F_NETWORK] = networkFail;
      cause[F_GAP_A] = sensorAOk && sensorBOk
         && (absDiff(angleA, angleB) > gapLimitA_reg);
      cause[F_GAP_B] = sensorAOk && sensorBOk
         && (absDiff(angleA, angleB) > gapLimitB_reg);
      cause[F_SUPPLY_UNDER] = supplyMv < SUPPLY_UNDER_MV;
      cause[F_SUPPLY_OVER] = supplyMv > SUPPLY_OVER_MV;
      cause[F_STORE] = storeBothBad;
      cause[F_SENSOR_A] = !angleAValid;
      cause[F_SENSOR_B] = dualFitted && !angleBValid;
      cause[F_POSITION] = (state_reg == ST_RUN) && (feedbackPos != activeDemand);
      cause[F_COLD_START] = 1'b0;
   end

   // set wins over the reset-edge clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         faults_reg <= FAULT_RESET;
      end else if (resetEdge) begin
         faults_reg <= cause;
      end else begin
         faults_reg <= faults_reg | cause;
      end
   end

   // store copy repair strobes
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         repairCopyA <= 1'b0;
         repairCopyB <= 1'b0;
      end else begin
         repairCopyA <= storeAccess && !copyAGood && copyBGood;
         repairCopyB <= storeAccess && copyAGood && !copyBGood;
      end
   end

   // ----------------------------------------
   // mismatch timer, millisecond ticks
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         msCount_reg <= 20'h00000;
      end else if (msCount_reg == MS_CYCLES_W - 20'h00001) begin
         msCount_reg <= 20'h00000;
      end else begin
         msCount_reg <= msCount_reg + 20'h00001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mismatchMs_reg <= 16'h0000;
      end else if (!mismatchOver) begin
         mismatchMs_reg <= 16'h0000;
      end else if (msCount_reg == MS_CYCLES_W - 20'h00001 && mismatchMs_reg != 16'hFFFF) begin
         mismatchMs_reg <= mismatchMs_reg + 16'h0001;
      end
   end

   // ----------------------------------------
   // shutdown state machine
   // ----------------------------------------
   logic sysFault;
   logic posFault;

   // internal faults force the harsher pwm closure
   assign sysFault = cause[F_STORE] || cause[F_SUPPLY_UNDER] || cause[F_SUPPLY_OVER]
      || (!sensorAOk && !sensorBOk);
   assign posFault = cause[F_ANALOG_OVER] || cause[F_ANALOG_UNDER] || cause[F_POSITION]
      || cause[F_GAP_B] || mismatchExpired || command_reg[CMD_SHUTDOWN]
      || (networkFail && !(command_reg[CMD_FALLBACK] && analogHealthy));

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (sysFault) state_next = ST_SYS_SHUTDOWN;
            else if (posFault) state_next = ST_POS_SHUTDOWN;
         end
         ST_POS_SHUTDOWN: begin
            if (sysFault) state_next = ST_SYS_SHUTDOWN;
            else if (resetEdge && !posFault) state_next = ST_RUN;
         end
         ST_SYS_SHUTDOWN: begin
            if (resetEdge && !sysFault && !posFault) state_next = ST_RUN;
         end
         default: state_next = ST_POS_SHUTDOWN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_POS_SHUTDOWN;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         currentCloseDrive <= 1'b0;
         pwmCloseDrive <= 1'b0;
         milliampZero <= 1'b1;
         statusShutdown <= 1'b1;
      end else begin
         currentCloseDrive <= (state_next == ST_POS_SHUTDOWN);
         pwmCloseDrive <= (state_next == ST_SYS_SHUTDOWN);
         milliampZero <= (state_next != ST_RUN);
         statusShutdown <= (state_next != ST_RUN) || command_reg[CMD_SHUTDOWN];
      end
   end

   // ----------------------------------------
   // manual sensor check
   // ----------------------------------------
   assign checkAllowed = command_reg[CMD_CHECK] && (state_reg != ST_RUN)
      && (feedbackPos == CLOSED_POS) && (activeDemand == CLOSED_POS);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sensorCheckRun <= 1'b0;
      end else begin
         sensorCheckRun <= checkAllowed;
      end
   end

   // ----------------------------------------
   // current filter, 0.002 step
   // ----------------------------------------
   logic signed [36:0] filtDelta;
   logic signed [49:0] filtStep;
   assign filtDelta = $signed({1'b0, currentSample, 20'h00000}) - $signed({1'b0, filt_reg});
   assign filtStep = (filtDelta * $signed({1'b0, FILT_COEFF})) >>> FILT_SHIFT;
   assign filteredCurrent = filt_reg[35:20];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         filt_reg <= 36'h0_0000_0000;
      end else if (currentStrobe) begin
         filt_reg <= 36'(filtStep[35:0] + filt_reg);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_OVER_SHUTS: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_reg == ST_RUN && !sysFault && cause[F_ANALOG_OVER]) |=> state_reg == ST_POS_SHUTDOWN)
      else $error("analog over did not shut down");
   AST_UNDER_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_b)
      cause[F_ANALOG_UNDER] |=> faults_reg[F_ANALOG_UNDER])
      else $error("analog under not latched");
   AST_NO_ANALOG_DIAG: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!analogUsed && resetEdge) |=> !faults_reg[F_ANALOG_OVER] && !faults_reg[F_ANALOG_UNDER])
      else $error("analog diagnostics while ignored");
   AST_MISMATCH_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($past(mismatchOver) && msCount_reg != 20'h00000) |-> $stable(mismatchMs_reg))
      else $error("mismatch expired early");
   AST_SUPPLY: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (supplyMv > SUPPLY_OVER_MV) |=> faults_reg[F_SUPPLY_OVER] && state_reg == ST_SYS_SHUTDOWN)
      else $error("supply over not handled");
   AST_NO_RESET_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_reg != ST_RUN && !resetEdge) |=> state_reg != ST_RUN)
      else $error("left shutdown without reset edge");
   AST_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (faults_reg[F_NETWORK] && !resetEdge) |=> faults_reg[F_NETWORK])
      else $error("fault dropped without reset");
   AST_CHECK_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
      sensorCheckRun |-> $past(state_reg) != ST_RUN && $past(command_reg[CMD_CHECK]))
      else $error("sensor check outside shutdown");
   AST_SD_CMD: assert property (@(posedge clk_sys) disable iff (!rst_b)
      command_reg[CMD_SHUTDOWN] |=> statusShutdown ##1 milliampZero)
      else $error("shutdown command ignored");
   AST_MA_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
      currentCloseDrive |-> milliampZero && statusShutdown && !pwmCloseDrive)
      else $error("position shutdown outputs wrong");
endmodule : valve_fault_supervisor

// *** test/plant_ctrl_model.sv ***
`timescale 1ns/10ps
module plant_ctrl_model
   import valve_supervisor_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [31:0] wbDatO,
   input wire logic wbAckO,
   output logic wbCycI,
   output logic wbStbI,
   output logic wbWeI,
   output logic [7:0] wbAdrI,
   output logic [3:0] wbSelI,
   output logic [31:0] wbDatI,
   output logic timedOut
);
   // ----------------------------------------
   // classic bus master of the control system
   // ----------------------------------------
   initial begin
      {wbCycI, wbStbI, wbWeI, timedOut, wbSelI} = 8'h0F;
      {wbAdrI, wbDatI} = 40'h0;
   end
   // request held until ack; a stuck slave ends the run
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n = 0;
      {wbCycI, wbStbI, wbWeI, wbAdrI, wbDatI} <= {2'h3, we, a, d};
      @(posedge clk_sys);
      while (wbAckO !== 1'h1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      q = wbDatO;
      timedOut <= (n == 50);
      // released data flips so a stale value never looks valid
      {wbCycI, wbStbI, wbDatI} <= {2'h0, ~d};
      @(posedge clk_sys);
   endtask : xfer
   task automatic clearReq(input logic [31:0] cmd);
      logic [31:0] q;
      xfer(1'h1, REG_COMMAND, cmd, q);
      xfer(1'h1, REG_COMMAND, cmd | 32'h2, q);
   endtask : clearReq
endmodule : plant_ctrl_model

// *** test/valve_fault_supervisor_tb.sv ***
`timescale 1ns/10ps
module valve_fault_supervisor_tb;
   import valve_supervisor_pkg::*;
   logic clk_sys, rst_b, wbCycI, wbStbI, wbWeI, wbAckO, timedOut, dualFitted, currentStrobe;
   logic angleAValid, angleBValid, storeAccess, copyAGood, copyBGood, repairCopyA;
   logic repairCopyB, currentCloseDrive, pwmCloseDrive, milliampZero, statusShutdown;
   logic sensorCheckRun, msgBad, nodeDuplicate, busOff, msgSilence;
   logic [7:0] wbAdrI;
   logic [3:0] wbSelI, netErr;
   logic [31:0] wbDatI, wbDatO, rd;
   logic [15:0] analogCurrentUa, analogDemand, networkDemand, supplyMv, angleA, angleB;
   logic [15:0] activeDemand, feedbackPos, filteredCurrent, currentSample;
   int badCount, numChecks;
   assign {msgSilence, busOff, nodeDuplicate, msgBad} = netErr;
   valve_fault_supervisor i_dut (.*);
   plant_ctrl_model i_plant (.*);
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // checking and reporting
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   always @(posedge timedOut) begin
      badCount++;
      summarize();
   end
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      i_plant.xfer(1'h0, a, 32'h0, rd);
      chk(rd & m, e);
   endtask : rdm
   // equal demands and readings keep the position check quiet
   task automatic calm(input logic [15:0] pos);
      {analogCurrentUa, supplyMv, netErr} <= {16'h2710, 16'h5DC0, 4'h0};
      {angleAValid, angleBValid, storeAccess} <= 3'h6;
      {analogDemand, networkDemand, angleA, angleB} <= {4{pos}};
      repeat (2) @(posedge clk_sys);
   endtask : calm
   task automatic heal(input logic [31:0] cmd);
      calm(16'h4000);
      i_plant.clearReq(cmd);
      repeat (3) @(posedge clk_sys);
   endtask : heal
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk({statusShutdown, milliampZero, currentCloseDrive}, 3'h7);
      rdm(REG_FAULTS, 32'hFFFFFFFF, 32'h1000);
      i_plant.xfer(1'h1, REG_FAULTS, 32'h0, rd);
      rdm(REG_FAULTS, 32'hFFFFFFFF, 32'h1000);
      rdm(8'h20, 32'hFFFFFFFF, 32'h0);
      heal(32'h0);
      rdm(REG_FAULTS, 32'hFFFFFFFF, 32'h0);
      rdm(REG_STATUS, 32'h1F, 32'h1);
   endtask : t_reset
   task automatic t_limits();
      logic [15:0] v [14] = '{16'h55F1, 16'h55F0, 16'h07CF, 16'h07D0, 16'h4267, 16'h4268,
         16'h80E9, 16'h80E8, 16'h1, 16'h2, 16'h4, 16'h8, 16'h0, 16'h0};
      logic [15:0] f [14] = '{16'h1, 16'h0, 16'h2, 16'h0, 16'h40, 16'h0, 16'h80, 16'h0,
         16'h8, 16'h8, 16'h8, 16'h8, 16'h200, 16'h400};
      for (int i = 0; i < 14; i++) begin
         heal(32'h10);
         case (i / 4)
            0: analogCurrentUa <= v[i];
            1: supplyMv <= v[i];
            2: netErr <= v[i][3:0];
            default: {angleAValid, angleBValid} <= {i == 13, i == 12};
         endcase
         repeat (3) @(posedge clk_sys);
         rdm(REG_FAULTS, 32'h1FFF, 32'(f[i]));
         chk(statusShutdown, 32'(i < 8 && i % 2 == 0));
         calm(16'h4000);
         rdm(REG_FAULTS, 32'h1FFF, 32'(f[i]));
      end
   endtask : t_limits
   task automatic t_demand();
      heal(32'h0);
      {analogCurrentUa, analogDemand} <= {16'h7000, 16'h4100};
      repeat (3) @(posedge clk_sys);
      chk(activeDemand, 16'h4000);
      rdm(REG_FAULTS, 32'h3, 32'h0);
      heal(32'h18);
      analogDemand <= 16'h4100;
      repeat (3) @(posedge clk_sys);
      chk(activeDemand, 16'h4100);
      heal(32'h10);
      {netErr, analogDemand} <= {4'h4, 16'h428F};
      repeat (3) @(posedge clk_sys);
      chk(activeDemand, 16'h428F);
      rdm(REG_FAULTS, 32'h4, 32'h0);
      analogDemand <= 16'h4290;
      repeat (3) @(posedge clk_sys);
      rdm(REG_FAULTS, 32'h4, 32'h4);
      i_plant.xfer(1'h1, REG_MISMATCH, 32'h0032_028F, rd);
      heal(32'h10);
      analogDemand <= 16'h4290;
      repeat (20) @(posedge clk_sys);
      chk({statusShutdown, activeDemand}, 17'h04000);
   endtask : t_demand
   task automatic t_pick();
      logic [15:0] e [3] = '{16'h4010, 16'h4000, 16'h4008};
      i_plant.xfer(1'h1, REG_GAP, 32'h0010000F, rd);
      heal(32'h0);
      angleB <= 16'h4010;
      for (int m = 0; m < 3; m++) begin
         i_plant.xfer(1'h1, REG_CONFIG, 32'(m), rd);
         repeat (2) @(posedge clk_sys);
         chk(feedbackPos, e[m]);
      end
      rdm(REG_FAULTS, 32'h30, 32'h10);
   endtask : t_pick
   task automatic t_shut();
      heal(32'h0);
      calm(16'h0000);
      i_plant.xfer(1'h1, REG_COMMAND, 32'h5, rd);
      repeat (2) @(posedge clk_sys);
      chk({statusShutdown, sensorCheckRun}, 2'h3);
      rdm(REG_STATUS, 32'h18, 32'h18);
   endtask : t_shut
   task automatic t_store();
      heal(32'h0);
      {storeAccess, copyAGood, copyBGood} <= 3'h5;
      @(posedge clk_sys);
      storeAccess <= 1'h0;
      #1;
      chk({repairCopyA, repairCopyB}, 2'h2);
      @(posedge clk_sys);
      {storeAccess, copyAGood, copyBGood} <= 3'h6;
      @(posedge clk_sys);
      storeAccess <= 1'h0;
      #1;
      chk({repairCopyA, repairCopyB}, 2'h1);
      @(posedge clk_sys);
      rdm(REG_FAULTS, 32'h100, 32'h0);
      {storeAccess, copyAGood, copyBGood} <= 3'h4;
      @(posedge clk_sys);
      storeAccess <= 1'h0;
      repeat (3) @(posedge clk_sys);
      rdm(REG_FAULTS, 32'h100, 32'h100);
      chk({pwmCloseDrive, currentCloseDrive, milliampZero}, 3'h5);
   endtask : t_store
   // full-scale step: 0.002 of 65535 is 131, then 261 after the second sample
   task automatic t_filter();
      {currentSample, currentStrobe} <= {16'hFFFF, 1'h1};
      @(posedge clk_sys);
      currentStrobe <= 1'h0;
      @(posedge clk_sys);
      chk(filteredCurrent, 16'h0083);
      currentStrobe <= 1'h1;
      @(posedge clk_sys);
      currentStrobe <= 1'h0;
      rdm(REG_FILTERED, 32'hFFFF, 32'h0105);
   endtask : t_filter
   initial begin
      badCount = 0;
      numChecks = 0;
      {rst_b, dualFitted, currentStrobe, copyAGood, copyBGood} = 5'h0B;
      currentSample = 16'h0000;
      calm(16'h4000);
      repeat (14) @(posedge clk_sys);
      rst_b <= 1'h1;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_limits();
      t_demand();
      t_pick();
      t_shut();
      t_store();
      t_filter();
      summarize();
   end
endmodule : valve_fault_supervisor_tb
